/* File: dfcp_map.svh */
`ifndef DFCP_MAP_SVH
`define DFCP_MAP_SVH
// ==========================================================
// Control port constants.
// Upper six bits of the chip address in two-wire format.
`define DFCP_ADDR_HI      6'h0c
// Full chip address in three-wire format.
`define DFCP_SPI_ADDR     7'h18
// Pointer reset value.
`define DFCP_PTR_RST      8'h00
// Pointer field positions.
`define DFCP_PTR_STEP_BIT 7
`define DFCP_PTR_IDX_MSB  4
// Auto-advance block limits.
`define DFCP_BLK1_FIRST   5'h01
`define DFCP_BLK1_LAST    5'h08
`define DFCP_BLK2_FIRST   5'h09
`define DFCP_BLK2_LAST    5'h1f
`endif

/* File: dfcp_pkg.sv */
// ==========================================================
// Types shared by the control port.
package dfcp_pkg;
  // Synchronised bus pins.
  typedef struct packed {
    logic scl;
    logic sda;
    logic sel;
  } dfcp_pins_s;
  // Register write request.
  typedef struct packed {
    logic       valid;
    logic [4:0] index;
    logic [7:0] data;
  } dfcp_wr_s;
endpackage

/* File: dfcp_top.sv */
`timescale 1ns/1ps
`include "dfcp_map.svh"
// How it works
// - Two slave formats: two-wire and three-wire.
// - Select falling edge after enable picks three-wire.
// - Two-wire address is 001100 plus pin.
// - Device acknowledges every byte it receives in a two-wire transfer whose address matches; three-wire has no acknowledge.
// - Write: start, address, pointer, data, stop.
// - More data bytes write more registers; without advance they rewrite the same one.
// - Read returns pointed register after address.
// - Three-wire pins are inputs, rising-edge sampled.
// - Three-wire format is write only.
// - Pointer byte then data byte after direction.
// - Pointer index bits 4..0, reset zero.
// - Pointer bit 7 enables auto-advance.
// - Advance within 01-08 and 09-up separately.
// - Without advance pointer stays fixed.
module dfcp_top (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Shared pins: address/select, clock, data in.
  input  wire logic        addr_bit_or_select,
  input  wire logic        control_serial_clock,
  input  wire logic        control_serial_data_in,
  // Open-drain data pin output side.
  output logic             sda_out,
  output logic             sda_oe,
  // Port enable from the device's settings.
  input  wire logic        control_port_on,
  // Register file side.
  output dfcp_pkg::dfcp_wr_s reg_wr,
  input  wire logic [7:0]  reg_rdata,
  output logic [7:0]       register_pointer,
  output logic             spi_mode
);
  import dfcp_pkg::*;

  // ==========================================================
  // Pin synchronisers.
  dfcp_pins_s s1_q, s2_q, s3_q;            // Two stages plus edge history.
  // Two flops before any logic looks at the pins.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= '{control_serial_clock, control_serial_data_in, addr_bit_or_select};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Edge detection waits until every stage holds a real pin sample.
  // Otherwise an address pin tied low would look like a select fall just after reset.
  logic [2:0] warm_q;                      // Fills with ones after reset.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      warm_q <= 3'h0;
    end else begin
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c, sel_fall;
  assign scl_rise = warm_q[2] & s2_q.scl & ~s3_q.scl;
  assign scl_fall = warm_q[2] & ~s2_q.scl & s3_q.scl;
  assign start_c  = warm_q[2] & s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
  assign stop_c   = warm_q[2] & s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
  assign sel_fall = warm_q[2] & s3_q.sel & ~s2_q.sel;

  // ==========================================================
  // Format selection: sticky once select falls after enable.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_mode <= 1'b0;
    end else if (control_port_on && sel_fall) begin
      spi_mode <= 1'b1;
    end
  end

  // ==========================================================
  // Byte engine shared by both formats.
  typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_DATA, ST_RD, ST_SKIP} dfcp_st_e;
  dfcp_st_e   st_q;                        // Transfer phase.
  logic [7:0] sh_q;                        // Receive shift register.
  logic [3:0] bit_q;                       // Bits in current byte.
  logic       ack_q;                       // Device drives acknowledge slot.
  logic       rdack_q;                     // Host acknowledge slot on reads.
  logic [7:0] tx_q;                        // Read shift register.
  logic       tx_on_q;                     // Device drives read data.
  logic       ack_pend_q;                  // Acknowledge owed at next falling edge.
  logic [7:0] byte_c;
  logic       spi_act, i2c_bit, spi_bit, byte_done, addr_ok;
  assign spi_act   = spi_mode & ~s2_q.sel;
  assign i2c_bit   = ~spi_mode & scl_rise & ~ack_q & ~rdack_q;
  assign spi_bit   = spi_act & scl_rise;
  assign byte_c    = {sh_q[6:0], s2_q.sda};
  assign byte_done = (i2c_bit | spi_bit) & (bit_q == 4'd7);
  assign addr_ok   = spi_mode ? (byte_c == {`DFCP_SPI_ADDR, 1'b0})
                   : (byte_c[7:2] == `DFCP_ADDR_HI && byte_c[1] == s2_q.sel);

  // Pointer advance: stays inside its block.
  function automatic logic [4:0] next_idx(input logic [4:0] i);
    if (i == `DFCP_BLK1_LAST) return `DFCP_BLK1_FIRST;
    if (i == `DFCP_BLK2_LAST) return `DFCP_BLK2_FIRST;
    return i + 5'd1;
  endfunction

  // Phase machine, shifting and pointer handling.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      rdack_q <= 1'b0;
      ack_pend_q <= 1'b0;
      tx_q <= 8'h00;
      tx_on_q <= 1'b0;
      register_pointer <= `DFCP_PTR_RST;
      reg_wr <= '0;
    end else begin
      reg_wr.valid <= 1'b0;
      // The select fall that picks three-wire format also opens its first frame.
      if ((!spi_mode && start_c) || ((spi_mode || control_port_on) && sel_fall)) begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        rdack_q <= 1'b0;
        ack_pend_q <= 1'b0;
        tx_on_q <= 1'b0;
      end else if ((!spi_mode && stop_c) || (spi_mode && s2_q.sel)) begin
        st_q <= ST_IDLE;
        ack_q <= 1'b0;
        rdack_q <= 1'b0;
        ack_pend_q <= 1'b0;
        tx_on_q <= 1'b0;
      end else begin
        // Acknowledge slot opens on the falling edge after a byte.
        if (scl_fall && ack_pend_q) begin
          ack_q <= 1'b1;
          ack_pend_q <= 1'b0;
        end else if (scl_fall && ack_q) begin
          ack_q <= 1'b0;
          if (st_q == ST_RD) begin
            tx_on_q <= 1'b1;
            tx_q <= reg_rdata;
          end
        end
        // Read shifting and host acknowledge.
        if (st_q == ST_RD && !ack_q && !ack_pend_q) begin
          if (rdack_q && scl_rise) begin
            if (s2_q.sda) st_q <= ST_SKIP;
          end else if (rdack_q && scl_fall) begin
            rdack_q <= 1'b0;
            tx_on_q <= 1'b1;
            tx_q <= reg_rdata;
          end else if (scl_rise && tx_on_q) begin
            bit_q <= bit_q + 4'd1;
          end else if (scl_fall && tx_on_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
            if (bit_q == 4'd8) begin
              bit_q <= 4'h0;
              tx_on_q <= 1'b0;
              rdack_q <= 1'b1;
              if (register_pointer[`DFCP_PTR_STEP_BIT])
                register_pointer[4:0] <= next_idx(register_pointer[4:0]);
            end
          end
        end
        if ((i2c_bit || spi_bit) && st_q != ST_IDLE && st_q != ST_SKIP && st_q != ST_RD) begin
          sh_q <= byte_c;
          bit_q <= byte_done ? 4'h0 : bit_q + 4'd1;
          if (byte_done) begin
            ack_pend_q <= ~spi_mode;
            unique case (st_q)
              ST_ADDR: begin
                if (!addr_ok || (spi_mode && byte_c[0])) begin
                  st_q <= ST_SKIP;
                  ack_pend_q <= 1'b0;
                end else if (byte_c[0]) begin
                  st_q <= ST_RD;
                end else begin
                  st_q <= ST_PTR;
                end
              end
              ST_PTR: begin
                register_pointer <= byte_c & 8'h9f;
                st_q <= ST_DATA;
              end
              ST_DATA: begin
                reg_wr <= '{1'b1, register_pointer[4:0], byte_c};
                if (register_pointer[`DFCP_PTR_STEP_BIT])
                  register_pointer[4:0] <= next_idx(register_pointer[4:0]);
              end
              default: st_q <= st_q;
            endcase
          end
        end
      end
    end
  end

  // Open-drain data: pull low for acknowledge or zero read bits.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) sda_oe <= 1'b0;
    else sda_oe <= ~spi_mode & (ack_q | (tx_on_q & ~tx_q[7]));
  end
  assign sda_out = 1'b0;

  // ==========================================================
  // Checks.
  ptr_reset_a: assert property (@(posedge sys_clk) $rose(rst_b) |-> register_pointer == 8'h00)
    else $error("pointer not reset");
  rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b) register_pointer[6:5] == 2'b00)
    else $error("reserved pointer bits set");
  spi_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b) spi_mode |=> spi_mode)
    else $error("format reverted");
  spi_silent_a: assert property (@(posedge sys_clk) disable iff (!rst_b) spi_mode |=> !sda_oe)
    else $error("drive in three-wire format");
  no_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_wr.valid && !register_pointer[7] |-> $stable(register_pointer))
    else $error("pointer moved");
  // A stepped write at the end of block one must wrap to its start, never carry on.
  blk_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_wr.valid && register_pointer[7] && reg_wr.index == `DFCP_BLK1_LAST
    |-> register_pointer[4:0] == `DFCP_BLK1_FIRST)
    else $error("block wrap");
  skip_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b) st_q == ST_SKIP |-> !reg_wr.valid)
    else $error("write on ignored transfer");
  ack_len_a: assert property (@(posedge sys_clk) disable iff (!rst_b) $rose(ack_q) |-> ack_q until scl_fall)
    else $error("ack dropped early");
  wr_cv: cover property (@(posedge sys_clk) reg_wr.valid && !spi_mode);
  spi_cv: cover property (@(posedge sys_clk) reg_wr.valid && spi_mode);
  rd_cv: cover property (@(posedge sys_clk) st_q == ST_RD && tx_on_q);
endmodule // dfcp_top

/* File: dfcp_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Host bus master: drives the shared pins at a 125 ns bit period.
module dfcp_host_model (
  // Pins towards the device.
  output logic     scl,
  output logic     sda_drv,
  output logic     sel,
  // Resolved data line, pulled up.
  input wire logic sda_in
);
  // Bus idle; the address pin is held high for two-wire.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    sel = 1'b1;
  end
  // One bit: data set while clock is low, line sampled mid-high.
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #31.25 scl = 1'b1;
    #31.25 s = sda_in;
    #31.25 scl = 0;
    #31.25;
  endtask
  // A byte MSB first, with an optional acknowledge slot.
  task automatic byte_io(input logic [7:0] tx, input logic ak, input logic ao,
                         output logic [7:0] rx, output logic ai);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    ai = 1'b1;
    if (ak) bit_io(ao, ai);
  endtask
  // The 1 ns offset keeps pin changes off the system clock edges.
  task automatic start_cond();
    #1 sda_drv = 1'b0;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  task automatic stop_cond();
    sda_drv = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_drv = 1'b1;
    #62.5;
  endtask
  // Select frames; clock stands still between them.
  task automatic sel_low();
    #1 scl = 1'b0;
    #31.25 sel = 1'b0;
    #31.25;
  endtask
  task automatic sel_high();
    #31.25 sel = 1'b1;
    sda_drv = ~sda_drv;
  endtask
  // Static level on the shared pin between two-wire transfers.
  task automatic hold_sel(input logic v);
    sel = v;
  endtask
endmodule // dfcp_host_model

/* File: testbench.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench: host frames in both formats, writes captured and compared.
module testbench;
  import dfcp_pkg::*;
  logic        sys_clk;
  logic        rst_b;
  logic        control_port_on;
  wire logic   scl;
  wire logic   sda_drv;
  wire logic   sel;
  wire logic   sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic        spi_mode;
  logic [7:0]  register_pointer;
  logic [7:0]  reg_rdata;
  dfcp_wr_s    reg_wr;
  logic [12:0] wq[$];
  logic [7:0]  rx;
  logic        ack;
  int          n_fail;
  int          n_checks;
  // Open-drain line with pull-up; register file answers c0 or index.
  assign sda_line = sda_oe ? (sda_out & sda_drv) : sda_drv;
  assign reg_rdata = 8'hc0 | {3'h0, register_pointer[4:0]};
  dfcp_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr_bit_or_select(sel),
    .control_serial_clock(scl), .control_serial_data_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .control_port_on(control_port_on), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .register_pointer(register_pointer), .spi_mode(spi_mode));
  dfcp_host_model host (.scl(scl), .sda_drv(sda_drv), .sel(sel), .sda_in(sda_line));
  // The system clock also stands for the audio master clock; it never stops.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Capture every register write as index and data, mid-pulse.
  always @(negedge sys_clk) begin
    if (reg_wr.valid === 1'b1) wq.push_back({reg_wr.index, reg_wr.data});
  end
  task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One frame of four bytes; two-wire frames check every acknowledge.
  task automatic frame(input logic spi, input logic [7:0] a, p, d0, d1, input logic na);
    logic [7:0] b[4];
    b = '{a, p, d0, d1};
    if (spi) host.sel_low();
    else host.start_cond();
    foreach (b[i]) begin
      host.byte_io(b[i], !spi, 1'b1, rx, ack);
      if (!spi) chk("ack", ack, na);
    end
    if (spi) host.sel_high();
    else host.stop_cond();
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic expect_wr(input int n, input logic [12:0] e0, e1);
    chk("write count", 13'(wq.size()), 13'(n));
    if (n > 0) chk("first write", wq[0], e0);
    if (n > 1) chk("second write", wq[1], e1);
    wq.delete();
    $display("test done, %0d writes", n);
  endtask
  // Two-byte two-wire read: host acknowledges the first byte, refuses the second.
  task automatic rd2(input logic [7:0] a, e0, e1);
    host.start_cond();
    host.byte_io(a, 1'b1, 1'b1, rx, ack);
    chk("read address ack", ack, 0);
    host.byte_io(8'hff, 1'b1, 1'b0, rx, ack);
    chk("read byte 0", rx, e0);
    host.byte_io(8'hff, 1'b1, 1'b1, rx, ack);
    chk("read byte 1", rx, e1);
    host.stop_cond();
    repeat (5) @(negedge sys_clk);
    $display("test done, read at %h", a);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    control_port_on = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("pointer reset", register_pointer, 8'h00);
    rd2(8'h33, 8'hc0, 8'hc0);
    host.hold_sel(1'b0);
    repeat (5) @(negedge sys_clk);
    chk("format while off", spi_mode, 0);
    frame(0, 8'h30, 8'he8, 8'ha1, 8'ha2, 0);
    expect_wr(2, {5'h08, 8'ha1}, {5'h01, 8'ha2});
    chk("pointer after write", register_pointer, 8'h82);
    rd2(8'h31, 8'hc2, 8'hc3);
    chk("pointer after read", register_pointer, 8'h84);
    frame(0, 8'h34, 8'h01, 8'h55, 8'h55, 1);
    expect_wr(0, 0, 0);
    chk("pointer after ignored frame", register_pointer, 8'h84);
    host.hold_sel(1'b1);
    control_port_on = 1'b1;
    repeat (5) @(negedge sys_clk);
    frame(1, 8'h30, 8'h9f, 8'h5a, 8'h5b, 0);
    chk("format after select fall", spi_mode, 1);
    expect_wr(2, {5'h1f, 8'h5a}, {5'h09, 8'h5b});
    frame(1, 8'h30, 8'h05, 8'h3c, 8'h3d, 0);
    expect_wr(2, {5'h05, 8'h3c}, {5'h05, 8'h3d});
    frame(1, 8'h31, 8'h07, 8'h11, 8'h22, 0);
    expect_wr(0, 0, 0);
    chk("pointer kept", register_pointer, 8'h05);
    tally_and_finish();
  end
endmodule // testbench
